// *** inc/adc_cfg_pkg.sv ***
// Register map, field layout and datapath constants of the output configuration bank
package adc_cfg_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets and table indices
   localparam int NREG = 5;
   localparam int IDX_TEST = 0;
   localparam int IDX_OFFSET = 1;
   localparam int IDX_FORMAT = 2;
   localparam int IDX_CLKPOL = 3;
   localparam int IDX_REFSEL = 4;
   localparam logic [7:0] ADDR_TEST = 8'h0D;
   localparam logic [7:0] ADDR_OFFSET = 8'h10;
   localparam logic [7:0] ADDR_FORMAT = 8'h14;
   localparam logic [7:0] ADDR_CLKPOL = 8'h16;
   localparam logic [7:0] ADDR_REFSEL = 8'h18;
   localparam logic [7:0] ADDR_UPDATE = 8'hFF;

   // Reset values
   localparam logic [7:0] RST_TEST = 8'h00;
   localparam logic [7:0] RST_OFFSET = 8'h00;
   localparam logic [7:0] RST_FORMAT = 8'h00;
   localparam logic [7:0] RST_CLKPOL = 8'h00;
   localparam logic [7:0] RST_REFSEL = 8'hC0;

   // Implemented bits; open positions read as zero
   localparam logic [7:0] MASK_TEST = 8'h37;
   localparam logic [7:0] MASK_OFFSET = 8'h3F;
   localparam logic [7:0] MASK_FORMAT = 8'hD7;
   localparam logic [7:0] MASK_CLKPOL = 8'h80;
   localparam logic [7:0] MASK_REFSEL = 8'hC0;

   localparam logic [7:0] REG_ADDR_TAB [NREG] = '{ADDR_TEST, ADDR_OFFSET, ADDR_FORMAT,
                                                  ADDR_CLKPOL, ADDR_REFSEL};
   localparam logic [7:0] REG_RST_TAB [NREG] = '{RST_TEST, RST_OFFSET, RST_FORMAT,
                                                 RST_CLKPOL, RST_REFSEL};
   localparam logic [7:0] REG_MASK_TAB [NREG] = '{MASK_TEST, MASK_OFFSET, MASK_FORMAT,
                                                  MASK_CLKPOL, MASK_REFSEL};

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int TP_SEL_LSB = 0;
   localparam int TP_SHORT_RST_BIT = 4;
   localparam int TP_LONG_RST_BIT = 5;
   localparam int OFS_LSB = 0;
   localparam int FMT_LSB = 0;
   localparam int INV_BIT = 2;
   localparam int DIS_BIT = 4;
   localparam int DRV_LSB = 6;
   localparam int CLKPOL_BIT = 7;
   localparam int REF_LSB = 6;
   localparam int XFER_BIT = 0;

   // Test pattern selections
   localparam logic [2:0] TP_OFF = 3'h0;
   localparam logic [2:0] TP_MID = 3'h1;
   localparam logic [2:0] TP_PFS = 3'h2;
   localparam logic [2:0] TP_NFS = 3'h3;
   localparam logic [2:0] TP_CHECK = 3'h4;
   localparam logic [2:0] TP_LONG = 3'h5;
   localparam logic [2:0] TP_SHORT = 3'h6;

   // Output data formats
   localparam logic [1:0] FMT_OFFBIN = 2'h0;
   localparam logic [1:0] FMT_TWOS = 2'h1;
   localparam logic [1:0] FMT_GRAY = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // Sample datapath
   localparam int SMP_W = 14;
   localparam logic [13:0] SMP_MID = 14'h2000;
   localparam logic [13:0] SMP_MAX = 14'h3FFF;
   localparam logic [13:0] SMP_MIN = 14'h0000;
   localparam logic [13:0] CHECK_A = 14'h2AAA;
   localparam logic [13:0] CHECK_B = 14'h1555;

   // Pseudo-random generators: stage count and feedback tap
   localparam int LONG_LEN = 23;
   localparam int LONG_TAP = 18;
   localparam int SHORT_LEN = 9;
   localparam int SHORT_TAP = 5;

   // Active configuration as seen by the datapath
   typedef struct packed {
      logic [2:0] test_sel;
      logic long_rst;
      logic short_rst;
      logic [5:0] offset;
      logic [1:0] format;
      logic invert;
      logic out_disable;
      logic [1:0] drv_cfg;
      logic clk_inv;
      logic [1:0] ref_sel;
   } cfg_t;

endpackage : adc_cfg_pkg

// *** core/prbs_gen.sv ***
// Linear feedback pseudo-random generator with a hold-in-reset control
`timescale 1ns/1ns
module prbs_gen
   import adc_cfg_pkg::*;
#(
   parameter int LEN = 9,
   parameter int TAP = 5
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic hold,
   input wire logic step,
   // Pattern word
   output logic [SMP_W-1:0] word
);

   logic [LEN-1:0] state_r;
   logic fb;

   ////////////////////////////////////////////////////////////////////////////////
   // Feedback from last stage and tap
   assign fb = state_r[LEN-1] ^ state_r[TAP-1];

   // Seed of all ones while held, since an all-zero state would lock up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '1;
      end else if (hold) begin
         state_r <= '1;
      end else if (step) begin
         state_r <= {state_r[LEN-2:0], fb};
      end
   end

   // Short generators repeat their stages across the upper word bits
   for (genvar b = 0; b < SMP_W; b++) begin : g_word
      assign word[b] = state_r[b % LEN];
   end

endmodule : prbs_gen

// *** core/adc_cfg_regs.sv ***
// Staged output configuration registers and the output data path they steer
//
// How it works
// - Signed six-bit offset added to samples
// - Test select replaces data with chosen pattern
// - Long sequence reset bit holds 23-stage generator
// - Short sequence reset bit holds 9-stage generator
// - Output disable bit turns data outputs off
// - Invert bit flips every output data bit
// - Format field: offset binary, twos, Gray
// - Driver field selects output driver configuration
// - Bit seven inverts output clock polarity
// - Reference select top bits, reset value C0
// - Writes staged, transfer bit makes them active
`timescale 1ns/1ns
module adc_cfg_regs
   import adc_cfg_pkg::*;
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   // Converted samples, offset binary
   input wire logic [SMP_W-1:0] SAMPLE_IN,
   input wire logic SAMPLE_VALID,
   // External output enable pin
   input wire logic EXT_OE_PIN,
   // Output data
   output logic [SMP_W-1:0] DATA_OUT,
   output logic DATA_VALID,
   output logic DATA_OE,
   // Static output controls
   output logic OUT_CLK_INV,
   output logic [1:0] DRV_CFG,
   output logic [1:0] REF_SEL
);

   logic [7:0] shadow_r [NREG];
   logic [7:0] active_r [NREG];
   logic [NREG-1:0] wr_hit;
   logic xfer;
   logic [7:0] rd_mux;
   logic [7:0] rdata_r;
   cfg_t cfg;
   logic oe_s1_r;
   logic oe_s2_r;
   logic check_r;
   logic [SMP_W-1:0] long_word;
   logic [SMP_W-1:0] short_word;
   logic [15:0] ofs_ext;
   logic [15:0] sum;
   logic [SMP_W-1:0] corrected;
   logic [SMP_W-1:0] pattern;
   logic [SMP_W-1:0] gray;
   logic [SMP_W-1:0] formatted;
   logic [SMP_W-1:0] data_nxt;
   logic [SMP_W-1:0] data_r;
   logic valid_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode
   assign xfer = REG_WR && (REG_ADDR == ADDR_UPDATE) && REG_WDATA[XFER_BIT];

   // Staged and active copies per register; the transfer bit itself is never stored
   for (genvar i = 0; i < NREG; i++) begin : g_reg
      assign wr_hit[i] = REG_WR && (REG_ADDR == REG_ADDR_TAB[i]);

      always_ff @(posedge CORE_CLK or negedge RST_N) begin
         if (!RST_N) begin
            shadow_r[i] <= REG_RST_TAB[i];
         end else if (wr_hit[i]) begin
            shadow_r[i] <= REG_WDATA & REG_MASK_TAB[i];
         end
      end

      // All registers move together so a format change never lands half-done
      always_ff @(posedge CORE_CLK or negedge RST_N) begin
         if (!RST_N) begin
            active_r[i] <= REG_RST_TAB[i];
         end else if (xfer) begin
            active_r[i] <= shadow_r[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read back the staged values; the update register and unmapped offsets read zero
   always_comb begin
      rd_mux = 8'h00;
      for (int i = 0; i < NREG; i++) begin
         if (REG_ADDR == REG_ADDR_TAB[i]) begin
            rd_mux = shadow_r[i];
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_r <= 8'h00;
      end else if (REG_RD) begin
         rdata_r <= rd_mux;
      end
   end

   assign REG_RDATA = rdata_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Field extraction from the active copies
   assign cfg.test_sel = active_r[IDX_TEST][TP_SEL_LSB +: 3];
   assign cfg.long_rst = active_r[IDX_TEST][TP_LONG_RST_BIT];
   assign cfg.short_rst = active_r[IDX_TEST][TP_SHORT_RST_BIT];
   assign cfg.offset = active_r[IDX_OFFSET][OFS_LSB +: 6];
   assign cfg.format = active_r[IDX_FORMAT][FMT_LSB +: 2];
   assign cfg.invert = active_r[IDX_FORMAT][INV_BIT];
   assign cfg.out_disable = active_r[IDX_FORMAT][DIS_BIT];
   assign cfg.drv_cfg = active_r[IDX_FORMAT][DRV_LSB +: 2];
   assign cfg.clk_inv = active_r[IDX_CLKPOL][CLKPOL_BIT];
   assign cfg.ref_sel = active_r[IDX_REFSEL][REF_LSB +: 2];

   // Static controls straight from the active flops
   assign OUT_CLK_INV = cfg.clk_inv;
   assign DRV_CFG = cfg.drv_cfg;
   assign REF_SEL = cfg.ref_sel;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser for the external enable
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         oe_s1_r <= 1'b0;
         oe_s2_r <= 1'b0;
      end else begin
         oe_s1_r <= EXT_OE_PIN;
         oe_s2_r <= oe_s1_r;
      end
   end

   // Drivers on only when the pin allows it and the disable bit is clear
   assign DATA_OE = oe_s2_r & ~cfg.out_disable;

   ////////////////////////////////////////////////////////////////////////////////
   // Pattern generators advance once per sample
   prbs_gen #(
      .LEN(LONG_LEN),
      .TAP(LONG_TAP)
   ) u_long (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .hold(cfg.long_rst),
      .step(SAMPLE_VALID),
      .word(long_word)
   );

   prbs_gen #(
      .LEN(SHORT_LEN),
      .TAP(SHORT_TAP)
   ) u_short (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .hold(cfg.short_rst),
      .step(SAMPLE_VALID),
      .word(short_word)
   );

   // Checkerboard phase alternates per sample
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         check_r <= 1'b0;
      end else if (SAMPLE_VALID) begin
         check_r <= ~check_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Offset correction with clamping; a wrap at the rails would look like full-scale swing
   assign ofs_ext = {{10{cfg.offset[5]}}, cfg.offset};
   assign sum = {2'b00, SAMPLE_IN} + ofs_ext;
   assign corrected = sum[15] ? SMP_MIN : (sum[14] ? SMP_MAX : sum[SMP_W-1:0]);

   // Test selection in place of converted data
   always_comb begin
      case (cfg.test_sel)
         TP_OFF: pattern = corrected;
         TP_MID: pattern = SMP_MID;
         TP_PFS: pattern = SMP_MAX;
         TP_NFS: pattern = SMP_MIN;
         TP_CHECK: pattern = check_r ? CHECK_B : CHECK_A;
         TP_LONG: pattern = long_word;
         TP_SHORT: pattern = short_word;
         default: pattern = corrected;
      endcase
   end

   // Output format, then inversion; code 11 falls back to offset binary
   assign gray = pattern ^ {1'b0, pattern[SMP_W-1:1]};
   always_comb begin
      case (cfg.format)
         FMT_OFFBIN: formatted = pattern;
         FMT_TWOS: formatted = {~pattern[SMP_W-1], pattern[SMP_W-2:0]};
         FMT_GRAY: formatted = gray;
         default: formatted = pattern;
      endcase
   end

   assign data_nxt = cfg.invert ? ~formatted : formatted;

   ////////////////////////////////////////////////////////////////////////////////
   // Output register, one cycle behind the sample
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         data_r <= SMP_MIN;
         valid_r <= 1'b0;
      end else begin
         valid_r <= SAMPLE_VALID;
         if (SAMPLE_VALID) begin
            data_r <= data_nxt;
         end
      end
   end

   assign DATA_OUT = data_r;
   assign DATA_VALID = valid_r;

endmodule : adc_cfg_regs

// *** testbench/adc_cfg_regs_monitor.sv ***
// Concurrent checks on the configuration bank ports
`timescale 1ns/1ns
module adc_cfg_regs_monitor
   import adc_cfg_pkg::*;
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_RD,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   // Data path and static controls
   input wire logic SAMPLE_VALID,
   input wire logic EXT_OE_PIN,
   input wire logic [SMP_W-1:0] DATA_OUT,
   input wire logic DATA_VALID,
   input wire logic DATA_OE,
   input wire logic OUT_CLK_INV,
   input wire logic [1:0] DRV_CFG,
   input wire logic [1:0] REF_SEL
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   ////////////////////////////////////////////////////////////////////////////////
   // Steps of a register access
   sequence s_rd(a);
      REG_RD && REG_ADDR == a;
   endsequence
   sequence s_xfer;
      REG_WR && REG_ADDR == ADDR_UPDATE && REG_WDATA[XFER_BIT];
   endsequence

   // Active controls may only move right after a transfer write
   property p_xfer;
      $changed({OUT_CLK_INV, DRV_CFG, REF_SEL}) |-> $past(REG_WR && REG_ADDR == ADDR_UPDATE
         && REG_WDATA[XFER_BIT]);
   endproperty
   // Pin passes two sync flops before it can enable the outputs
   property p_oe;
      DATA_OE |-> $past(EXT_OE_PIN, 2);
   endproperty
   property p_dv;
      DATA_VALID == $past(SAMPLE_VALID);
   endproperty
   property p_hold;
      !SAMPLE_VALID |=> $stable(DATA_OUT);
   endproperty
   property p_rd_upd;
      s_rd(ADDR_UPDATE) or s_xfer |=> REG_RDATA == 8'h00 || !$past(REG_RD);
   endproperty
   property p_rd_fmt;
      s_rd(ADDR_FORMAT) |=> (REG_RDATA & ~MASK_FORMAT) == 8'h00;
   endproperty
   property p_rd_pol;
      s_rd(ADDR_CLKPOL) |=> (REG_RDATA & ~MASK_CLKPOL) == 8'h00;
   endproperty
   property p_rd_ref;
      s_rd(ADDR_REFSEL) |=> (REG_RDATA & ~MASK_REFSEL) == 8'h00;
   endproperty

   a_xfer: assert property (p_xfer) else $error("control moved without transfer");
   a_oe: assert property (p_oe) else $error("outputs enabled with pin low");
   a_dv: assert property (p_dv) else $error("data valid not one cycle late");
   a_hold: assert property (p_hold) else $error("data changed without sample");
   a_rd_upd: assert property (p_rd_upd) else $error("transfer register read nonzero");
   a_rd_fmt: assert property (p_rd_fmt) else $error("format open bits set");
   a_rd_pol: assert property (p_rd_pol) else $error("polarity open bits set");
   a_rd_ref: assert property (p_rd_ref) else $error("reference open bits set");
endmodule : adc_cfg_regs_monitor

bind adc_cfg_regs adc_cfg_regs_monitor mon_u (.CORE_CLK, .RST_N, .REG_ADDR, .REG_RD, .REG_WR,
   .REG_WDATA, .REG_RDATA, .SAMPLE_VALID, .EXT_OE_PIN, .DATA_OUT, .DATA_VALID, .DATA_OE,
   .OUT_CLK_INV, .DRV_CFG, .REF_SEL);

// *** testbench/adc_host_model.sv ***
// Host side model that programs the bank and drives the output enable pin
`timescale 1ns/1ns
module adc_host_model (
   // Clock
   input wire logic clk,
   // Register port toward the bank
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [7:0] rdata,
   // External output enable pin
   output logic oe_pin
);
   // Idle bus, pin held high so the register enable can act
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      oe_pin = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Released lines show the inverse, so stale values never look valid
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      @(negedge clk);
      d = rdata;
   endtask : rd_reg
   // Staged values become active only through the transfer bit
   task automatic xfer();
      wr_reg(8'hFF, 8'h01);
   endtask : xfer
   task automatic set_oe(input logic v);
      @(posedge clk);
      oe_pin <= v;
   endtask : set_oe
endmodule : adc_host_model

// *** testbench/adc_cfg_regs_tb.sv ***
// Self-checking bench for the output configuration bank
`timescale 1ns/1ns
module adc_cfg_regs_tb;
   import adc_cfg_pkg::*;
   typedef struct packed {
      logic [7:0] tp;
      logic [7:0] ofs;
      logic [7:0] fmt;
      logic [13:0] smp;
      logic [13:0] exp;
   } row_t;
   localparam int NROW = 17;
   // Test select, offset, format word, sample in, data out expected
   localparam row_t ROWS [NROW] = '{'{8'h00, 8'h00, 8'h00, 14'h1234, 14'h1234},
      '{8'h00, 8'h1F, 8'h00, 14'h1000, 14'h101F}, '{8'h00, 8'h20, 8'h00, 14'h1000, 14'h0FE0},
      '{8'h00, 8'h1F, 8'h00, 14'h3FF0, 14'h3FFF}, '{8'h00, 8'h20, 8'h00, 14'h0010, 14'h0000},
      '{8'h00, 8'h00, 8'h01, 14'h1234, 14'h3234}, '{8'h00, 8'h00, 8'h02, 14'h1234, 14'h1B2E},
      '{8'h00, 8'h00, 8'h04, 14'h1234, 14'h2DCB}, '{8'h01, 8'h1F, 8'h00, 14'h1234, 14'h2000},
      '{8'h02, 8'h00, 8'h00, 14'h1234, 14'h3FFF}, '{8'h03, 8'h00, 8'h00, 14'h1234, 14'h0000},
      '{8'h25, 8'h00, 8'h00, 14'h1234, 14'h3FFF}, '{8'h16, 8'h00, 8'h00, 14'h1234, 14'h3FFF},
      '{8'h02, 8'h00, 8'h05, 14'h0000, 14'h2000}, '{8'h00, 8'h00, 8'h10, 14'h1234, 14'h1234},
      '{8'h00, 8'h00, 8'hC3, 14'h1234, 14'h1234}, '{8'h07, 8'h00, 8'h80, 14'h1234, 14'h1234}};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr, wdata, rdata, rv;
   logic wr, rd, oe_pin, dvalid, oe, clk_inv;
   logic [13:0] smp_in = 14'h0000;
   logic smp_valid = 1'b0;
   logic [13:0] dout, a, b;
   logic [1:0] drv, refsel;
   int bad_count = 0;
   int checked = 0;
   int i;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, design and host
   initial begin
      forever #20 clk = ~clk;
   end
   adc_cfg_regs dut_u (.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SAMPLE_IN(smp_in), .SAMPLE_VALID(smp_valid),
      .EXT_OE_PIN(oe_pin), .DATA_OUT(dout), .DATA_VALID(dvalid), .DATA_OE(oe),
      .OUT_CLK_INV(clk_inv), .DRV_CFG(drv), .REF_SEL(refsel));
   adc_host_model host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .oe_pin(oe_pin));

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic smp(input logic [13:0] v, output logic [13:0] q);
      @(posedge clk);
      smp_in <= v;
      smp_valid <= 1'b1;
      @(posedge clk);
      smp_valid <= 1'b0;
      @(negedge clk);
      q = dout;
   endtask : smp
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
   endtask : do_reset
   task automatic test_done();
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done

   // Watchdog well beyond the expected run
   initial begin
      #400000;
      bad_count++;
      test_done();
   end

   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < NROW; i++) begin
         host_u.wr_reg(ADDR_TEST, ROWS[i].tp);
         host_u.wr_reg(ADDR_OFFSET, ROWS[i].ofs);
         host_u.wr_reg(ADDR_FORMAT, ROWS[i].fmt);
         host_u.xfer();
         smp(ROWS[i].smp, a);
         chk(a, ROWS[i].exp);
         chk({13'h0, oe}, {13'h0, ~ROWS[i].fmt[DIS_BIT]});
         chk({12'h0, drv}, {12'h0, ROWS[i].fmt[7:6]});
         $display("row %0d done", i);
      end
      // Second reset in mid-run, then reset values
      do_reset();
      for (i = 0; i < NREG; i++) begin
         host_u.rd_reg(REG_ADDR_TAB[i], rv);
         chk({6'h0, rv}, {6'h0, REG_RST_TAB[i]});
      end
      chk({12'h0, refsel}, 14'h0003);
      // Staging, masking and an unmapped place
      host_u.wr_reg(ADDR_CLKPOL, 8'hFF);
      host_u.rd_reg(ADDR_CLKPOL, rv);
      chk({6'h0, rv}, 14'h0080);
      chk({13'h0, clk_inv}, 14'h0000);
      host_u.wr_reg(ADDR_REFSEL, 8'h7F);
      host_u.xfer();
      // Active copies load on the transfer edge; look once they have settled
      @(negedge clk);
      chk({13'h0, clk_inv}, 14'h0001);
      chk({12'h0, refsel}, 14'h0001);
      // The transfer bit is never stored, so the update register reads zero
      host_u.rd_reg(ADDR_UPDATE, rv);
      chk({6'h0, rv}, 14'h0000);
      host_u.wr_reg(8'h20, 8'hAA);
      host_u.rd_reg(8'h20, rv);
      chk({6'h0, rv}, 14'h0000);
      $display("register test done");
      // Checkerboard alternates between complementary words
      host_u.wr_reg(ADDR_TEST, 8'h04);
      host_u.xfer();
      smp(14'h0000, a);
      smp(14'h0000, b);
      chk(a ^ b, 14'h3FFF);
      chk({13'h0, a === CHECK_A || a === CHECK_B}, 14'h0001);
      // Released generators must move from sample to sample
      for (i = 5; i < 7; i++) begin
         host_u.wr_reg(ADDR_TEST, i[7:0]);
         host_u.xfer();
         smp(14'h0000, a);
         smp(14'h0000, b);
         chk({13'h0, a !== b}, 14'h0001);
      end
      $display("pattern test done");
      // Pin low turns the outputs off after the sync flops
      host_u.set_oe(1'b0);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({13'h0, oe}, 14'h0000);
      host_u.set_oe(1'b1);
      // Pin high again with the disable bit clear brings the drivers back
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({13'h0, oe}, 14'h0001);
      $display("enable pin test done");
      test_done();
   end
endmodule : adc_cfg_regs_tb
